// [src/lcs_pkg.sv]
// Shared constants and types for the panel column sampling controller
package lcs_pkg;

  // ==========================================================
  // Geometry
  localparam int COLS = 120;

  // ==========================================================
  // Register map, byte addresses
  localparam logic [3:0] REG_CTRL  = 4'h0;
  localparam logic [3:0] REG_STAT  = 4'h4;
  localparam logic [3:0] REG_LINES = 4'h8;

  // Control fields and reset value
  localparam int          CTRL_EN_BIT = 0;
  localparam logic [31:0] CTRL_RESET  = 32'h0000_0001;

  // Status field positions
  localparam int STAT_MUXON_BIT = 0;
  localparam int STAT_BANK_BIT  = 1;
  localparam int STAT_PHASE_LSB = 2;
  localparam int STAT_ARR_LSB   = 4;
  localparam int STAT_STATE_LSB = 8;

  // Colour route code when no input is routed
  localparam logic [1:0] COLOUR_NONE = 2'h3;

  // ==========================================================
  // Arrangement, coded as {first selector, second selector}
  typedef enum logic [1:0] {
    ARR_STRIPE = 2'h0,
    ARR_BAD    = 2'h1,
    ARR_MOSAIC = 2'h2,
    ARR_DELTA  = 2'h3
  } lcs_arr_t;

  // Shift register sequencer
  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_ARMED = 5'h02,
    ST_TRIG  = 5'h04,
    ST_RUN   = 5'h08,
    ST_DONE  = 5'h10
  } lcs_state_t;

  // Pin inputs that cross into the clk domain
  typedef struct packed {
    logic sclk;
    logic blank;
    logic sel_rst;
    logic psave;
    logic sel1;
    logic sel2;
    logic dir;
    logic casc_r;
    logic casc_l;
  } lcs_pins_t;

endpackage

// [src/lcs_sync3.sv]
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module lcs_sync3 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  // ==========================================================
  // Stage chain; s1 feeds only s2
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Accept a bit only once stages two and three agree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2[i] == s3[i]) begin
          q[i] <= s3[i];
        end
      end
    end
  end

endmodule

// [src/lcs_pulse_shift.sv]
// Bidirectional one-hot sampling pulse shift register
`timescale 1ns/1ns
module lcs_pulse_shift import lcs_pkg::*; (
  input  wire logic            clk,
  input  wire logic            rst,
  input  wire logic            clear,
  input  wire logic            seed,
  input  wire logic            adv,
  input  wire logic            right,
  output logic      [COLS-1:0] vec,
  output logic                 last
);

  // ==========================================================
  // Clear wins, then seed, then advance
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      vec <= '0;
    end else if (clear) begin
      vec <= '0;
    end else if (seed) begin
      vec <= right ? COLS'(1) : {1'b1, {(COLS-1){1'b0}}};
    end else if (adv) begin
      vec <= right ? {vec[COLS-2:0], 1'b0} : {1'b0, vec[COLS-1:1]};
    end
  end

  // Pulse sits on the final column of this direction
  assign last = right ? vec[COLS-1] : vec[0];

endmodule

// [src/lcs_column_ctrl.sv]
// Column sampling control of a 120-column panel source driver
//
// Behaviour
// - Right shift: start in on right cascade pin, out on left; left shift swaps.
// - Direction high samples column 1 upward; low samples column 120 downward.
// - Incoming cascade start pulse is captured on a shift clock rising edge.
// - Sequential sampling advances on both shift clock edges.
// - Simultaneous sampling advances on the rising shift clock edge only.
// - Blanking strobe high forces every column output high for precharge.
// - Blanking strobe fall steps colour mux and swaps the two hold banks.
// - Selector reset high returns mux and bank selectors to initial state.
// - Power save high forces outputs high and reduces amplifier bias.
// - Both selectors low select stripe mode, mux passing colours straight through.
// - Stripe and mosaic sample simultaneously; delta samples sequentially.
// - Stripe maps colours 1,2,3 for right shift and 3,2,1 for left.
// - A start pulse stretched half a clock or more still starts normally.
// - Both selectors high select delta mode, sequential with per-line rotation.
// - First high, second low selects mosaic, rotating colours each line.
// - Trigger is clock low with cascade in high; stop once cascade out emitted.
`timescale 1ns/1ns
module lcs_column_ctrl import lcs_pkg::*; (
  input  wire logic            clk,
  input  wire logic            rst,
  input  wire logic [3:0]      avs_address,
  input  wire logic            avs_read,
  input  wire logic            avs_write,
  input  wire logic [31:0]     avs_writedata,
  output logic      [31:0]     avs_readdata,
  output logic                 avs_waitrequest,
  input  wire logic            shift_clock_in,
  input  wire logic            blank_precharge_strobe,
  input  wire logic            selector_reset_in,
  input  wire logic            power_save_in,
  input  wire logic            arrangement_sel_first,
  input  wire logic            arrangement_sel_second,
  input  wire logic            shift_dir_right,
  input  wire logic            cascade_pin_right_in,
  output logic                 cascade_pin_right_out,
  output logic                 cascade_pin_right_oe,
  input  wire logic            cascade_pin_left_in,
  output logic                 cascade_pin_left_out,
  output logic                 cascade_pin_left_oe,
  output logic      [COLS-1:0] sampling_pulse_n,
  output logic                 column_force_high,
  output logic                 bias_reduce,
  output logic      [1:0]      colour_route,
  output logic      [1:0]      mux_phase,
  output logic                 sample_bank
);

  // ==========================================================
  // Helpers

  // Sum modulo three of two values below three
  function automatic logic [1:0] add3(input logic [1:0] a, input logic [1:0] b);
    logic [2:0] s;
    s = {1'b0, a} + {1'b0, b};
    return (s >= 3'h3) ? 2'(s - 3'h3) : s[1:0];
  endfunction

  // Colour input index for the k-th sampled column of a line
  function automatic logic [1:0] colour_of(input lcs_arr_t a, input logic right,
                                           input logic [1:0] k, input logic [1:0] ph,
                                           input logic bk);
    logic [1:0] r;
    r = 2'h0;
    unique case (a)
      ARR_MOSAIC: r = add3(k, ph);
      ARR_DELTA:  r = add3(k, {1'b0, bk});
      default:    r = k;
    endcase
    if (a == ARR_MOSAIC || a == ARR_DELTA) begin
      return (right || r == 2'h0) ? r : 2'(2'h3 - r);
    end
    return right ? r : 2'(2'h2 - r);
  endfunction

  // ==========================================================
  // Pin synchronisation and edge detection
  lcs_pins_t  raw;
  lcs_pins_t  pin;
  lcs_pins_t  prev;
  logic [$bits(lcs_pins_t)-1:0] pin_bits;

  assign raw = '{sclk: shift_clock_in, blank: blank_precharge_strobe,
                 sel_rst: selector_reset_in, psave: power_save_in,
                 sel1: arrangement_sel_first, sel2: arrangement_sel_second,
                 dir: shift_dir_right, casc_r: cascade_pin_right_in,
                 casc_l: cascade_pin_left_in};
  assign pin = lcs_pins_t'(pin_bits);

  lcs_sync3 #(
    .W ($bits(lcs_pins_t))
  ) u_sync (
    .clk (clk),
    .rst (rst),
    .d   (raw),
    .q   (pin_bits)
  );

  // Previous filtered levels for edge detection
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prev <= '0;
    end else begin
      prev <= pin;
    end
  end

  logic     sclk_rise;
  logic     sclk_fall;
  logic     blank_fall;
  logic     casc_in;
  lcs_arr_t arr;
  logic     sequential;

  assign sclk_rise  = pin.sclk & ~prev.sclk;
  assign sclk_fall  = ~pin.sclk & prev.sclk;
  assign blank_fall = ~pin.blank & prev.blank;
  assign casc_in    = pin.dir ? pin.casc_r : pin.casc_l;
  assign arr        = lcs_arr_t'({pin.sel1, pin.sel2});
  assign sequential = (arr == ARR_DELTA);

  // ==========================================================
  // Register file
  logic [31:0] ctrl;
  logic [15:0] lines;
  lcs_state_t  state;
  logic        mux_on;
  logic        acc;
  logic        acc_ok;

  assign acc    = avs_read | avs_write;
  assign acc_ok = acc & ~avs_waitrequest;

  // One wait cycle per access, then release for one cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~(acc & avs_waitrequest);
    end
  end

  // Read data settle during the wait cycle; unmapped reads give zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      avs_readdata <= '0;
    end else if (avs_read && avs_waitrequest) begin
      unique case (avs_address)
        REG_CTRL:  avs_readdata <= ctrl;
        REG_STAT:  avs_readdata <= {19'h0, state, 2'h0, arr, mux_phase,
                                    sample_bank, mux_on};
        REG_LINES: avs_readdata <= {16'h0, lines};
        default:   avs_readdata <= '0;
      endcase
    end
  end

  // Control write at the released edge; other offsets ignore writes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl <= CTRL_RESET;
    end else if (acc_ok && avs_write && avs_address == REG_CTRL) begin
      ctrl <= {31'h0, avs_writedata[CTRL_EN_BIT]};
    end
  end

  // ==========================================================
  // Mux and hold bank selectors
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mux_phase   <= 2'h0;
      sample_bank <= 1'b0;
      mux_on      <= 1'b0;
    end else if (pin.sel_rst) begin
      mux_phase   <= 2'h0;
      sample_bank <= 1'b0;
      mux_on      <= 1'b0;
    end else if (blank_fall) begin
      mux_phase   <= add3(mux_phase, 2'h1);
      sample_bank <= ~sample_bank;
      mux_on      <= 1'b1;
    end
  end

  // Line count for software, wraps
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lines <= 16'h0;
    end else if (pin.sel_rst) begin
      lines <= 16'h0;
    end else if (blank_fall) begin
      lines <= lines + 16'h1;
    end
  end

  // ==========================================================
  // Sampling sequencer
  logic [COLS-1:0] vec;
  logic            last;
  logic            adv;
  logic            seed;
  logic            clear;
  logic            casc_out;
  logic [1:0]      kcol;

  // Sequential steps on both clock edges, simultaneous on rising only
  assign adv   = (state == ST_RUN) && (sclk_rise || (sequential && sclk_fall));
  assign seed  = (state == ST_TRIG) && sclk_rise && !pin.sel_rst && !blank_fall;
  assign clear = pin.sel_rst || blank_fall || (adv && last);

  lcs_pulse_shift u_shift (
    .clk   (clk),
    .rst   (rst),
    .clear (clear),
    .seed  (seed),
    .adv   (adv),
    .right (pin.dir),
    .vec   (vec),
    .last  (last)
  );

  // Stretched start pulses are ignored once running; rearm needs a blank fall
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
    end else if (pin.sel_rst) begin
      state <= ST_IDLE;
    end else if (blank_fall) begin
      state <= ST_ARMED;
    end else begin
      unique case (state)
        ST_IDLE:  state <= ST_IDLE;
        ST_ARMED: if (!pin.sclk && casc_in) begin
          state <= ST_TRIG;
        end
        ST_TRIG:  if (sclk_rise) begin
          state <= ST_RUN;
        end
        ST_RUN:   if (adv && last) begin
          state <= ST_DONE;
        end
        ST_DONE:  state <= ST_DONE;
        default:  state <= ST_IDLE;
      endcase
    end
  end

  // Column position modulo three for colour routing
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      kcol <= 2'h0;
    end else if (seed) begin
      kcol <= 2'h0;
    end else if (adv) begin
      kcol <= add3(kcol, 2'h1);
    end
  end

  // Cascade out rises after the last column and holds until the next rising edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      casc_out <= 1'b0;
    end else if (pin.sel_rst || blank_fall) begin
      casc_out <= 1'b0;
    end else if (adv && last) begin
      casc_out <= 1'b1;
    end else if (sclk_rise) begin
      casc_out <= 1'b0;
    end
  end

  // ==========================================================
  // Output registers
  // Pin direction follows the shift direction; only the far pin drives
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cascade_pin_right_out <= 1'b0;
      cascade_pin_right_oe  <= 1'b0;
      cascade_pin_left_out  <= 1'b0;
      cascade_pin_left_oe   <= 1'b0;
    end else begin
      cascade_pin_left_oe   <= pin.dir;
      cascade_pin_right_oe  <= ~pin.dir;
      cascade_pin_left_out  <= pin.dir & casc_out;
      cascade_pin_right_out <= ~pin.dir & casc_out;
    end
  end

  // Pulses are withheld until the mux has seen its first blank pulse
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sampling_pulse_n <= '0;
      colour_route     <= COLOUR_NONE;
    end else if (mux_on && ctrl[CTRL_EN_BIT] && state == ST_RUN) begin
      sampling_pulse_n <= vec;
      colour_route     <= colour_of(arr, pin.dir, kcol, mux_phase, sample_bank);
    end else begin
      sampling_pulse_n <= '0;
      colour_route     <= COLOUR_NONE;
    end
  end

  // Precharge and power save both pull every column high
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      column_force_high <= 1'b0;
      bias_reduce       <= 1'b0;
    end else begin
      column_force_high <= pin.blank | pin.psave;
      bias_reduce       <= pin.psave;
    end
  end

  // ==========================================================
  // Checks
  blank_force_a: assert property (
    @(posedge clk) disable iff (rst) pin.blank |=> column_force_high)
    else $error("precharge not forced");

  psave_force_a: assert property (
    @(posedge clk) disable iff (rst) pin.psave |=> column_force_high && bias_reduce)
    else $error("power save not applied");

  bank_swap_a: assert property (
    @(posedge clk) disable iff (rst)
    blank_fall && !pin.sel_rst |=> sample_bank != $past(sample_bank)
                                   && mux_on && state == ST_ARMED)
    else $error("bank not swapped on blank fall");

  sel_reset_a: assert property (
    @(posedge clk) disable iff (rst)
    pin.sel_rst |=> mux_phase == 2'h0 && !sample_bank && !mux_on)
    else $error("selectors not reset");

  start_capture_a: assert property (
    @(posedge clk) disable iff (rst) seed |=> state == ST_RUN && vec != '0)
    else $error("start not captured");

  dir_seed_a: assert property (
    @(posedge clk) disable iff (rst)
    seed |=> (pin.dir ? vec[0] : vec[COLS-1]))
    else $error("wrong first column");

  simul_edge_a: assert property (
    @(posedge clk) disable iff (rst)
    state == ST_RUN && !sequential && !sclk_rise && !clear |=> $stable(vec))
    else $error("simultaneous moved off rising edge");

  seq_edge_a: assert property (
    @(posedge clk) disable iff (rst)
    state == ST_RUN && sequential && sclk_fall && !clear |=> vec != $past(vec))
    else $error("sequential missed falling edge");

  casc_emit_a: assert property (
    @(posedge clk) disable iff (rst)
    adv && last && !pin.sel_rst && !blank_fall |=> casc_out && state == ST_DONE
                                                  ##1 vec == '0)
    else $error("cascade out not emitted");

  pin_dir_a: assert property (
    @(posedge clk) disable iff (rst)
    pin.dir |=> cascade_pin_left_oe && !cascade_pin_right_oe)
    else $error("cascade pin roles wrong");

  run_seen_c: cover property (@(posedge clk) disable iff (rst) seed);
  casc_seen_c: cover property (@(posedge clk) disable iff (rst) adv && last);
  delta_run_c: cover property (@(posedge clk) disable iff (rst)
    state == ST_RUN && sequential && sclk_fall);
  left_run_c: cover property (@(posedge clk) disable iff (rst) seed && !pin.dir);

endmodule

// [test/lcs_panel_model.sv]
// Panel timing controller model that drives one display line per call
`timescale 1ns/1ns
module lcs_panel_model #(
  parameter int HALF = 5
) (
  input  wire logic clk,
  output logic      sclk,
  output logic      blank,
  output logic      dir,
  output logic      drv_r,
  output logic      drv_l,
  input  wire logic pin_r,
  input  wire logic pin_l
);
  logic start;
  logic seen;
  logic clr;

  // ==========================================================
  // Start pulse only on the input-side pin; the other one idles low
  assign drv_r = dir & start;
  assign drv_l = ~dir & start;

  // Sticky flag: the driver handed the pulse on to its neighbour
  always_ff @(posedge clk) begin
    if (clr)
      seen <= 1'b0;
    else if (dir ? pin_l : pin_r)
      seen <= 1'b1;
  end

  initial begin
    sclk = 1'b0;
    blank = 1'b0;
    dir = 1'b1;
    start = 1'b0;
    clr = 1'b1;
  end

  // ==========================================================
  // One shift clock period, low half first; HALF=5 keeps it at 5 MHz
  task automatic sclk_cycle();
    sclk <= 1'b0;
    repeat (HALF) @(posedge clk);
    sclk <= 1'b1;
    repeat (HALF) @(posedge clk);
  endtask

  // Strobe, three clocks, then start pulse held for hold periods
  task automatic run(input logic right, input int hold, output int rises);
    clr <= 1'b1;
    dir <= right;
    blank <= 1'b1;
    repeat (10) @(posedge clk);
    clr <= 1'b0;
    blank <= 1'b0;
    repeat (3) sclk_cycle();
    rises = 0;
    start <= 1'b1;
    while (seen !== 1'b1 && rises < 200) begin
      if (rises == hold)
        start <= 1'b0;
      sclk_cycle();
      rises++;
    end
    start <= 1'b0;
    repeat (4) sclk_cycle();
    sclk <= 1'b0;
    repeat (10) @(posedge clk);
  endtask
endmodule

// [test/lcs_column_ctrl_tb.sv]
// Self-checking testbench for the column sampling controller
`timescale 1ns/1ns
module lcs_column_ctrl_tb import lcs_pkg::*;;
  // ==========================================================
  // Bench signals
  localparam logic [COLS-1:0] ONE = 1;
  localparam logic [1:0] CODES [3] = '{2'h2, 2'h3, 2'h0};
  logic clk, rst, rd, wr, sel_rst, psave, sel1, sel2, bank, force_hi, bias_lo;
  logic sclk, blank, dir, drv_r, drv_l, r_out, r_oe, l_out, l_oe, waitreq;
  logic [3:0] addr;
  logic [31:0] wdata, rdata, d;
  logic [1:0] colour, phase, exp_col;
  logic [COLS-1:0] pulses, prev;
  int errors, tests_run, mon_step, rises, blank_cnt, colour_chk, col_off;
  // Released cascade pins read the panel model's drive
  wire pin_r = r_oe ? r_out : drv_r;
  wire pin_l = l_oe ? l_out : drv_l;

  lcs_column_ctrl dut (
    .clk(clk), .rst(rst), .avs_address(addr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wdata), .avs_readdata(rdata), .avs_waitrequest(waitreq),
    .shift_clock_in(sclk), .blank_precharge_strobe(blank), .selector_reset_in(sel_rst),
    .power_save_in(psave), .arrangement_sel_first(sel1), .arrangement_sel_second(sel2),
    .shift_dir_right(dir), .cascade_pin_right_in(pin_r), .cascade_pin_right_out(r_out),
    .cascade_pin_right_oe(r_oe), .cascade_pin_left_in(pin_l), .cascade_pin_left_out(l_out),
    .cascade_pin_left_oe(l_oe), .sampling_pulse_n(pulses), .column_force_high(force_hi),
    .bias_reduce(bias_lo), .colour_route(colour), .mux_phase(phase), .sample_bank(bank));
  lcs_panel_model pm (.clk(clk), .sclk(sclk), .blank(blank), .dir(dir), .drv_r(drv_r),
    .drv_l(drv_l), .pin_r(pin_r), .pin_l(pin_l));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ==========================================================
  // Shared compare, report and bus tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] e, input string s);
    tests_run++;
    if (got !== e) begin
      errors++;
      $display("BAD t=%0t %s got %h exp %h", $time, s, got, e);
    end
  endtask

  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] v,
                     output logic [31:0] q);
    addr <= a;
    wr <= w;
    rd <= ~w;
    wdata <= v;
    // Wait for the slave; only the watchdog ends a hung access
    do begin
      @(posedge clk);
    end while (waitreq !== 1'b0);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr32(input logic [3:0] a, input logic [31:0] v);
    logic [31:0] q;
    bus(1'b1, a, v, q);
  endtask

  task automatic rd32(input logic [3:0] a, input logic [31:0] e, input string s);
    bus(1'b0, a, 32'h0, d);
    chk(d, e, s);
  endtask

  // Line through the panel model, then a bound on shift clocks used
  task automatic line(input logic right, input int hold, input int lo, input int hi);
    mon_step = 0;
    pm.run(right, hold, rises);
    tests_run++;
    if (rises < lo || rises > hi) begin
      errors++;
      $display("BAD t=%0t line took %0d shift clocks", $time, rises);
    end
  endtask

  task automatic done(input string s);
    $display("test %s finished, mismatches %0d", s, errors);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ==========================================================
  // Pulse walk monitor: each new pulse is the next column in order
  always @(posedge clk) begin
    if (pulses !== prev && pulses !== '0) begin
      exp_col = 2'((mon_step + col_off) % 3);
      if (!dir)
        exp_col = (colour_chk == 2) ? 2'((3 - exp_col) % 3) : 2'(2 - exp_col);
      tests_run++;
      if (pulses !== (ONE << (dir ? mon_step : COLS - 1 - mon_step))) begin
        errors++;
        $display("BAD t=%0t pulse %0d out of order", $time, mon_step);
      end
      if (colour_chk != 0)
        chk({30'h0, colour}, {30'h0, exp_col}, "colour");
      mon_step++;
    end
    prev = pulses;
    blank_cnt = (blank === 1'b1) ? blank_cnt + 1 : 0;
    if (blank_cnt == 8)
      chk({31'h0, force_hi}, 32'h1, "precharge");
  end

  // Hang guard, well past the longest expected run
  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    $display("BAD t=%0t watchdog expired", $time);
    end_sim();
  end

  // ==========================================================
  // Test sequence
  initial begin
    rst = 1'b1;
    sel_rst = 1'b1;
    {psave, sel1, sel2, rd, wr, addr, wdata} = '0;
    {errors, tests_run, mon_step, blank_cnt, colour_chk, col_off} = '0;
    prev = '0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    sel_rst <= 1'b0;
    repeat (8) @(posedge clk);
    rd32(REG_CTRL, CTRL_RESET, "ctrl");
    rd32(REG_STAT, 32'h0000_0100, "stat");
    rd32(REG_LINES, 32'h0, "lines");
    chk({30'h0, colour}, {30'h0, COLOUR_NONE}, "route");
    wr32(REG_STAT, 32'hFFFF_FFFF);
    wr32(4'hC, 32'hFFFF_FFFF);
    rd32(REG_STAT, 32'h0000_0100, "stat ro");
    rd32(4'hC, 32'h0, "unmapped");
    done("reset");
    // The prohibited code is never applied
    for (int i = 0; i < 3; i++) begin
      sel1 <= CODES[i][1];
      sel2 <= CODES[i][0];
      repeat (8) @(posedge clk);
      bus(1'b0, REG_STAT, 32'h0, d);
      chk({30'h0, d[5:4]}, {30'h0, CODES[i]}, "arrangement");
    end
    done("arrangement");
    colour_chk = 1;
    line(1'b1, 1, 120, 124);
    chk(mon_step, 120, "walk right");
    chk({30'h0, l_oe, r_oe}, 32'h2, "oe right");
    rd32(REG_LINES, 32'h1, "lines");
    bus(1'b0, REG_STAT, 32'h0, d);
    chk({30'h0, d[1:0]}, 32'h3, "mux bank");
    done("stripe right");
    line(1'b0, 2, 120, 124);
    chk(mon_step, 120, "walk left");
    chk({30'h0, l_oe, r_oe}, 32'h1, "oe left");
    bus(1'b0, REG_STAT, 32'h0, d);
    chk({30'h0, d[1:0]}, 32'h1, "bank swap");
    done("stripe left");
    // Third blank fall leaves bank 1, so delta colours rotate by one
    colour_chk = 2;
    col_off = 1;
    sel1 <= 1'b1;
    sel2 <= 1'b1;
    repeat (8) @(posedge clk);
    line(1'b1, 1, 59, 64);
    chk(mon_step, 120, "walk delta");
    done("delta");
    // Fourth blank fall leaves mux phase 1 for the mosaic line
    sel2 <= 1'b0;
    repeat (8) @(posedge clk);
    line(1'b0, 1, 120, 124);
    chk(mon_step, 120, "walk mosaic");
    colour_chk = 0;
    sel1 <= 1'b0;
    done("mosaic");
    psave <= 1'b1;
    repeat (8) @(posedge clk);
    chk({30'h0, force_hi, bias_lo}, 32'h3, "power save");
    psave <= 1'b0;
    repeat (8) @(posedge clk);
    chk({30'h0, force_hi, bias_lo}, 32'h0, "power save off");
    done("power save");
    sel_rst <= 1'b1;
    repeat (6) @(posedge clk);
    sel_rst <= 1'b0;
    repeat (8) @(posedge clk);
    chk({29'h0, phase, bank}, 32'h0, "selectors");
    rd32(REG_LINES, 32'h0, "lines");
    done("selector reset");
    wr32(REG_CTRL, 32'h0);
    line(1'b1, 1, 0, 200);
    chk(mon_step, 0, "disabled");
    wr32(REG_CTRL, 32'h1);
    rd32(REG_CTRL, 32'h1, "ctrl");
    done("disable");
    end_sim();
  end
endmodule
